// file: rtl/i2c_evt_pkg.sv
// Purpose: Shared constants for the bus event timing and wait control block
// Assumes: Status byte layout and event clock counts fixed by the bus controller
package i2c_evt_pkg;

  // ==========================================================
  // Status byte layout
  localparam int unsigned ST_MASTER_BIT = 7;
  localparam int unsigned ST_ALD_BIT    = 6;
  localparam int unsigned ST_EXC_BIT    = 5;
  localparam int unsigned ST_COI_BIT    = 4;
  localparam int unsigned ST_TRC_BIT    = 3;
  localparam int unsigned ST_ACKD_BIT   = 2;
  localparam int unsigned ST_START_BIT  = 1;
  localparam int unsigned ST_SPD_BIT    = 0;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam logic [7:0]  STATUS_STOP   = 8'h01;

  // ==========================================================
  // Clock counts, address decoding and synchroniser width
  localparam logic [3:0]  CNT_EARLY     = 4'h8;
  localparam logic [3:0]  CNT_LATE      = 4'h9;
  localparam logic [3:0]  EXT_NIB_LO    = 4'h0;
  localparam logic [3:0]  EXT_NIB_HI    = 4'hF;
  localparam int unsigned ADDR_W_DEF    = 7;
  localparam int unsigned SYNC_W        = 3;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_SKIP = 4'h8
  } seq_state_t;

endpackage

// file: rtl/link_capture.sv
// Purpose: Serial data capture running on the serial clock itself
// Assumes: Data is stable at each rising edge of the serial clock
// Notes:   The toggle marks each captured bit; the word stays still until the next edge

module link_capture (
  // Link clock and reset
  input  wire logic       link_clk,
  input  wire logic       rst,
  // Bus data
  input  wire logic       sda_in,
  // Captured bits toward the core domain
  output logic [8:0]      bits,
  output logic            bit_toggle
);

  typedef struct packed {
    logic [8:0] shreg;
    logic       tgl;
  } link_t;

  link_t r_reg;
  link_t r_next;

  // ==========================================================
  // Shift one bit per rising serial clock edge
  always_comb begin
    r_next       = r_reg;
    r_next.shreg = {r_reg.shreg[7:0], sda_in};
    r_next.tgl   = ~r_reg.tgl;
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bits       = r_reg.shreg;
  assign bit_toggle = r_reg.tgl;

endmodule // link_capture

// file: rtl/i2c_event_timing_and_wait_control.sv
// Purpose: Interrupt timing, wait insertion and status patterns of the bus controller
// Assumes: Arbitration engine sits outside and reports by ports; data bits are captured inside by link_capture
// Notes:   All event decisions run on core_clk from synchronised line levels and the bit word captured by link_capture

module i2c_event_timing_and_wait_control
  import i2c_evt_pkg::*;
#(
  parameter int unsigned ADDR_W = i2c_evt_pkg::ADDR_W_DEF
) (
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Serial clock pin (also the link clock)
  input  wire logic              serial_clock_line,
  output logic                   serial_clock_line_out,
  output logic                   serial_clock_line_oe,
  // Serial data pin
  input  wire logic              serial_data_line,
  output logic                   serial_data_line_out,
  output logic                   serial_data_line_oe,
  // Control bits
  input  wire logic              wait_clock_select,
  input  wire logic              auto_ack_enable,
  input  wire logic              stop_irq_enable,
  input  wire logic              local_release,
  input  wire logic              wait_release,
  input  wire logic [ADDR_W-1:0] own_address_reg,
  // Arbitration engine
  input  wire logic              master_active,
  input  wire logic              arb_loss,
  input  wire logic              arb_loss_clear,
  // Status and event
  output logic [7:0]             bus_status_reg,
  output logic                   bus_event_irq
);

  import i2c_evt_pkg::*;

  if (ADDR_W != ADDR_W_DEF) begin : g_width_check
    $error("ADDR_W must equal the seven-bit address width");
  end

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
    logic              scl_d;
    logic              sda_d;
    logic              tgl_d;
    seq_state_t        st;
    logic [3:0]        cnt;
    logic [8:0]        bits;
    logic              was_addr;
    logic              mis;
    logic              wait_on;
    logic              ack_drv;
    logic              irq;
    logic [7:0]        status;
    logic              evt_data;
    logic              evt_addr;
    logic [3:0]        evt_cnt;
  } core_t;

  core_t r_reg;
  core_t r_next;

  logic [8:0] link_bits;
  logic       link_tgl;

  // ==========================================================
  // Link domain capture
  link_capture u_link (
    .link_clk   (serial_clock_line),
    .rst        (rst),
    .sda_in     (serial_data_line),
    .bits       (link_bits),
    .bit_toggle (link_tgl)
  );

  // ==========================================================
  // Line events seen from the core domain
  logic       scl_s;
  logic       sda_s;
  logic       tgl_s;
  logic       fe;
  logic       start_c;
  logic       stop_c;
  logic       bit_in;
  logic [7:0] addr_byte;
  logic       ext_code;
  logic       addr_match;
  logic       master_now;

  assign scl_s      = r_reg.sync[0];
  assign sda_s      = r_reg.sync[1];
  assign tgl_s      = r_reg.sync[2];
  assign fe         = r_reg.scl_d & ~scl_s;
  assign start_c    = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
  assign stop_c     = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
  assign bit_in     = tgl_s ^ r_reg.tgl_d;
  assign addr_byte  = r_reg.bits[7:0];
  assign ext_code   = (addr_byte[7:4] == EXT_NIB_LO) | (addr_byte[7:4] == EXT_NIB_HI);
  assign addr_match = (addr_byte[7:1] == own_address_reg);
  assign master_now = master_active & ~r_reg.status[ST_ALD_BIT];

  // ==========================================================
  // Sequencer
  always_comb begin
    r_next          = r_reg;
    r_next.meta     = {link_tgl, serial_data_line, serial_clock_line};
    r_next.sync     = r_reg.meta;
    r_next.scl_d    = scl_s;
    r_next.sda_d    = sda_s;
    r_next.tgl_d    = tgl_s;
    r_next.irq      = 1'b0;
    r_next.evt_data = 1'b0;
    r_next.evt_addr = 1'b0;
    r_next.status[ST_MASTER_BIT] = master_now;

    // The word was stable since the toggle flipped on the serial clock
    if (bit_in) begin
      r_next.bits = link_bits;
      r_next.cnt  = r_reg.cnt + 4'h1;
    end

    if (fe && r_reg.cnt == CNT_LATE) begin
      r_next.cnt     = 4'h0;
      r_next.ack_drv = 1'b0;
    end

    unique case (r_reg.st)
      ST_IDLE, ST_SKIP: begin
      end
      ST_ADDR: begin
        if (fe && r_reg.cnt == CNT_EARLY) begin
          r_next.status[ST_TRC_BIT] = master_now ? ~addr_byte[0] : addr_byte[0];
          r_next.mis                = 1'b0;
          if (master_now) begin
            r_next.status[ST_COI_BIT] = 1'b0;
            r_next.status[ST_EXC_BIT] = ext_code;
          end else if (addr_match) begin
            r_next.status[ST_COI_BIT] = 1'b1;
            r_next.status[ST_EXC_BIT] = ext_code;
            r_next.ack_drv            = 1'b1;
          end else if (ext_code) begin
            r_next.status[ST_COI_BIT]  = 1'b0;
            r_next.status[ST_EXC_BIT]  = 1'b1;
            r_next.status[ST_ACKD_BIT] = 1'b0;
            r_next.ack_drv             = auto_ack_enable;
            r_next.irq                 = 1'b1;
            r_next.wait_on             = 1'b1;
            r_next.evt_addr            = 1'b1;
            r_next.evt_cnt             = CNT_EARLY;
          end else begin
            r_next.status[ST_COI_BIT] = 1'b0;
            r_next.status[ST_EXC_BIT] = 1'b0;
            r_next.mis                = 1'b1;
            if (!r_reg.was_addr) begin
              r_next.st = ST_SKIP;
            end
          end
        end else if (fe && r_reg.cnt == CNT_LATE) begin
          r_next.status[ST_ACKD_BIT] = ~r_reg.bits[0];
          r_next.evt_cnt             = CNT_LATE;
          if (r_reg.mis) begin
            r_next.irq      = 1'b1;
            r_next.evt_addr = 1'b1;
            r_next.st       = ST_SKIP;
          end else if (master_now || r_reg.status[ST_COI_BIT]) begin
            r_next.irq      = 1'b1;
            r_next.wait_on  = 1'b1;
            r_next.evt_addr = 1'b1;
            r_next.st       = ST_DATA;
          end else if (r_reg.status[ST_EXC_BIT]) begin
            r_next.st = ST_DATA;
            if (wait_clock_select) begin
              r_next.irq      = 1'b1;
              r_next.wait_on  = 1'b1;
              r_next.evt_addr = 1'b1;
            end
          end else begin
            r_next.st = ST_SKIP;
          end
        end
      end
      ST_DATA: begin
        if (fe && r_reg.cnt == CNT_EARLY) begin
          r_next.status[ST_START_BIT] = 1'b0;
          r_next.status[ST_ACKD_BIT]  = 1'b0;
          if (!r_reg.status[ST_TRC_BIT] && auto_ack_enable) begin
            r_next.ack_drv = 1'b1;
          end
          if (!wait_clock_select) begin
            r_next.irq      = 1'b1;
            r_next.wait_on  = 1'b1;
            r_next.evt_data = 1'b1;
            r_next.evt_cnt  = CNT_EARLY;
          end
        end else if (fe && r_reg.cnt == CNT_LATE) begin
          r_next.status[ST_ACKD_BIT] = ~r_reg.bits[0];
          if (wait_clock_select) begin
            r_next.irq      = 1'b1;
            r_next.wait_on  = 1'b1;
            r_next.evt_data = 1'b1;
            r_next.evt_cnt  = CNT_LATE;
          end
          if (!master_now && !r_reg.status[ST_COI_BIT] && !r_reg.status[ST_EXC_BIT]) begin
            r_next.st = ST_SKIP;
          end
        end
      end
    endcase

    // A transfer in ST_SKIP is not addressed to us and is no longer ours to stretch
    if (r_next.st == ST_SKIP) begin
      r_next.wait_on = 1'b0;
    end

    if (wait_release) begin
      r_next.wait_on = 1'b0;
    end

    // After a loss the lines stay released unless addressed as slave again
    if (r_reg.status[ST_ALD_BIT]
        && !r_next.status[ST_COI_BIT] && !r_next.status[ST_EXC_BIT]) begin
      r_next.wait_on = r_next.wait_on & r_reg.wait_on;
      r_next.ack_drv = r_next.ack_drv & r_reg.ack_drv;
    end

    if (local_release) begin
      r_next.st                 = ST_SKIP;
      r_next.wait_on            = 1'b0;
      r_next.ack_drv            = 1'b0;
      r_next.status[ST_COI_BIT] = 1'b0;
      r_next.status[ST_EXC_BIT] = 1'b0;
    end

    if (start_c) begin
      r_next.was_addr = r_reg.status[ST_COI_BIT] | r_reg.status[ST_EXC_BIT];
      r_next.mis      = 1'b0;
      r_next.st       = ST_ADDR;
      r_next.cnt      = 4'h0;
      r_next.wait_on  = 1'b0;
      r_next.ack_drv  = 1'b0;
      r_next.status[ST_SPD_BIT]   = 1'b0;
      r_next.status[ST_START_BIT] = 1'b1;
    end

    if (stop_c) begin
      r_next.st       = ST_IDLE;
      r_next.cnt      = 4'h0;
      r_next.wait_on  = 1'b0;
      r_next.ack_drv  = 1'b0;
      r_next.was_addr = 1'b0;
      r_next.mis      = 1'b0;
      r_next.status   = STATUS_STOP;
      r_next.status[ST_MASTER_BIT] = master_now;
      r_next.status[ST_ALD_BIT]    = r_reg.status[ST_ALD_BIT];
      r_next.irq      = stop_irq_enable;
      r_next.evt_data = 1'b0;
      r_next.evt_addr = 1'b0;
    end

    // Loss flag: a new loss beats a clear in the same cycle
    if (arb_loss_clear) begin
      r_next.status[ST_ALD_BIT] = 1'b0;
    end
    if (arb_loss) begin
      r_next.status[ST_ALD_BIT]    = 1'b1;
      r_next.status[ST_MASTER_BIT] = 1'b0;
      r_next.status[ST_TRC_BIT]    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg        <= '0;
      r_reg.st     <= ST_IDLE;
      r_reg.status <= STATUS_RST;
      r_reg.meta   <= 3'h3;
      r_reg.sync   <= 3'h3;
      r_reg.scl_d  <= 1'b1;
      r_reg.sda_d  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign serial_clock_line_out = 1'b0;
  assign serial_clock_line_oe  = r_reg.wait_on;
  assign serial_data_line_out  = 1'b0;
  assign serial_data_line_oe   = r_reg.ack_drv;
  assign bus_status_reg        = r_reg.status;
  assign bus_event_irq         = r_reg.irq;

  // ==========================================================
  // Checks
  sequence s_match_seen;
    (r_reg.st == ST_ADDR) && fe && (r_reg.cnt == CNT_EARLY) && !master_now && addr_match;
  endsequence

  sequence s_ack_drive;
    serial_data_line_oe [*2];
  endsequence

  irq_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_event_irq |=> !bus_event_irq)
    else $error("event pulse longer than one cycle");

  wait_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(serial_clock_line_oe) |-> bus_event_irq && $past(fe))
    else $error("wait began away from a falling edge");

  wait_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    serial_clock_line_oe && !wait_release && !local_release && !start_c && !stop_c
      |=> serial_clock_line_oe)
    else $error("wait dropped without release");

  data_timing_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_event_irq && r_reg.evt_data
      |-> r_reg.evt_cnt == ($past(wait_clock_select) ? CNT_LATE : CNT_EARLY))
    else $error("data event on wrong clock");

  master_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_event_irq && r_reg.evt_addr && bus_status_reg[ST_MASTER_BIT]
      |-> r_reg.evt_cnt == CNT_LATE)
    else $error("master address event not on ninth clock");

  ext_eighth_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_event_irq && r_reg.evt_addr && r_reg.evt_cnt == CNT_EARLY
      |-> bus_status_reg[ST_EXC_BIT] && bus_status_reg[ST_START_BIT]
          && !bus_status_reg[ST_ACKD_BIT] && !bus_status_reg[ST_COI_BIT])
    else $error("extension event status wrong");

  match_ack_a: assert property (@(posedge core_clk) disable iff (rst)
    s_match_seen ##1 !start_c && !stop_c && !local_release |-> s_ack_drive)
    else $error("matched address not acknowledged");

  stop_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(stop_c) |-> (bus_event_irq == $past(stop_irq_enable))
                      && bus_status_reg[5:0] == STATUS_STOP[5:0])
    else $error("stop event wrong");

  skip_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    r_reg.st == ST_SKIP && $past(r_reg.st) == ST_SKIP
      |-> (!bus_event_irq || bus_status_reg[ST_SPD_BIT]) && !serial_clock_line_oe)
    else $error("event while not addressed");

endmodule // i2c_event_timing_and_wait_control

// file: dv/bus_master_model.sv
// Purpose: Behavioural far-side master driving the serial clock and data lines
// Assumes: Both lines are open drain with pull-ups; the device pulls low by its enables
// Notes:   The clock low phase is stretched after the eighth and ninth clocks
module bus_master_model (
  // Device pin enables
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  // Resolved lines and observation
  output logic            scl,
  output logic            sda,
  output logic [3:0]      clk_no,
  output logic            ack_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_rel = 1'b1;
  logic sda_rel = 1'b1;
  assign scl = scl_rel & ~scl_oe;
  assign sda = sda_rel & ~sda_oe;
  initial clk_no = 4'h0;
  initial ack_low = 1'b0;
  // ==========================================================
  // Clock release that waits out a held-low wait
  task automatic rise();
    int n;
    scl_rel = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 2000) begin
      #1;
      n++;
    end
    #7.5;
  endtask
  task automatic clock_bit(input logic b, input logic hold);
    #3.75 sda_rel = b;
    #3.75 rise();
    ack_low = ~sda;
    scl_rel = 1'b0;
    clk_no  = clk_no + 4'h1;
    if (hold) #60;
  endtask
  // Ack set means this side drives the ninth bit low
  task automatic send_byte(input logic [7:0] d, input logic ack);
    clk_no = 4'h0;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], i == 0);
    clock_bit(~ack, 1'b1);
  endtask
  task automatic start_cond();
    #3.75 sda_rel = 1'b1;
    #3.75 rise();
    #30 sda_rel = 1'b0;
    #30 scl_rel = 1'b0;
    clk_no = 4'h0;
  endtask
  task automatic stop_cond();
    #3.75 sda_rel = 1'b0;
    #3.75 rise();
    #30 sda_rel = 1'b1;
    clk_no = 4'h0;
    #60;
  endtask
endmodule // bus_master_model

// file: dv/i2c_event_timing_and_wait_control_bench.sv
// Purpose: Self-checking bench for event timing, wait and status patterns
// Assumes: Wait is ended by the bench a few cycles after each event
// Notes:   Status bits shown as don't-care are masked out
module i2c_event_timing_and_wait_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_evt_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wcs, aack, spie, lrel, mact, aloss, aclr;
  logic        wrel = 1'b0;
  logic [6:0]  own;
  wire logic   scl, sda, scl_oe, sda_oe;
  logic [7:0]  status;
  logic        irq, ack_low, scl_o, sda_o;
  logic [3:0]  clk_no;
  logic [31:0] seed = 32'h27;
  logic [31:0] r;
  int          bad_count = 0, check_count = 0, cycles = 0;
  int          e_cnt[$], e_oe[$];
  logic [7:0]  e_m[$], e_v[$], g_st[$];
  logic [3:0]  g_cnt[$];
  logic        g_oe[$];
  always #2.5 core_clk = ~core_clk;
  i2c_event_timing_and_wait_control DUT (
    .core_clk(core_clk), .rst(rst), .serial_clock_line(scl), .serial_clock_line_out(scl_o),
    .serial_clock_line_oe(scl_oe), .serial_data_line(sda), .serial_data_line_out(sda_o),
    .serial_data_line_oe(sda_oe), .wait_clock_select(wcs), .auto_ack_enable(aack),
    .stop_irq_enable(spie), .local_release(lrel), .wait_release(wrel),
    .own_address_reg(own), .master_active(mact), .arb_loss(aloss),
    .arb_loss_clear(aclr), .bus_status_reg(status), .bus_event_irq(irq));
  bus_master_model BM (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .clk_no(clk_no), .ack_low(ack_low));
  // ==========================================================
  // Checking helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    check_count++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h mask %h", $time, got, exp, m);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  // Oe code 2 leaves the wait unchecked
  task automatic ev(input int c, input logic [7:0] m, input logic [7:0] v, input int o);
    e_cnt.push_back(c);
    e_m.push_back(m);
    e_v.push_back(v);
    e_oe.push_back(o);
  endtask
  task automatic check_events();
    int o;
    check8(8'(g_st.size()), 8'(e_v.size()), 8'hFF);
    while (g_st.size() > 0 && e_v.size() > 0) begin
      check8({4'h0, g_cnt.pop_front()}, 8'(e_cnt.pop_front()), 8'hFF);
      check8(g_st.pop_front(), e_v.pop_front(), e_m.pop_front());
      o = e_oe.pop_front();
      if (o != 2) check1(g_oe.pop_front(), o[0]);
      else void'(g_oe.pop_front());
    end
    g_cnt.delete(); g_st.delete(); g_oe.delete();
    e_cnt.delete(); e_m.delete(); e_v.delete(); e_oe.delete();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Clears the loss flag and confirms it dropped
  task automatic clear_loss();
    @(negedge core_clk);
    aclr = 1'b1;
    @(negedge core_clk);
    aclr = 1'b0;
    @(negedge core_clk);
    check8(status, 8'h00, 8'h40);
  endtask
  // Event logger; ends each wait a few cycles later
  always @(posedge core_clk) begin
    if (irq === 1'b1) begin
      g_cnt.push_back(clk_no);
      g_st.push_back(status);
      repeat (2) @(negedge core_clk);
      g_oe.push_back(scl_oe);
      wrel = 1'b1;
      @(negedge core_clk);
      wrel = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("FAIL %0t timeout", $time);
      finish_test();
    end
  end
  // ==========================================================
  // Scenarios, once per select value
  initial begin
    {wcs, aack, spie, lrel, mact, aloss, aclr} = '0;
    own = 7'h35;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (6) @(negedge core_clk);
    #1.3;
    for (int s = 0; s < 2; s++) begin
      r = rnd();
      @(negedge core_clk);
      wcs = s[0]; aack = r[8]; spie = 1'b1; own = {2'b01, r[4:0]};
      ev(9, 8'hF7, 8'h16, 1);
      if (s == 1) ev(9, 8'hF3, 8'h10, 1);
      else ev(8, 8'hF7, 8'h10, 1);
      ev(0, 8'hFF, 8'h01, 2);
      BM.start_cond();
      BM.send_byte({own, 1'b0}, 1'b0);
      check1(ack_low, 1'b1);
      BM.send_byte(r[23:16], 1'b0);
      BM.stop_cond();
      check_events();
      @(negedge core_clk);
      spie = 1'b0;
      BM.start_cond();
      BM.send_byte({own ^ 7'h01, 1'b0}, 1'b1);
      BM.send_byte(r[15:8], 1'b1);
      BM.stop_cond();
      check_events();
      check8(status, 8'h01, 8'h01);
      @(negedge core_clk);
      aack = 1'b1; spie = 1'b1;
      ev(8, 8'hF7, 8'h22, 2);
      if (s == 1) begin
        ev(9, 8'hF7, 8'h26, 2);
        ev(9, 8'hF3, 8'h20, 2);
        ev(9, 8'hF7, 8'h16, 1);
        ev(9, 8'hF3, 8'h10, 1);
      end else begin
        ev(8, 8'hF7, 8'h20, 2);
        ev(9, 8'hFB, 8'h02, 0);
      end
      ev(0, 8'hFF, 8'h01, 2);
      BM.start_cond();
      BM.send_byte(8'h00, 1'b0);
      BM.send_byte(r[31:24], 1'b0);
      BM.start_cond();
      BM.send_byte(s == 1 ? {own, 1'b0} : {own ^ 7'h02, 1'b0}, s == 0);
      BM.send_byte(r[7:0], 1'b0);
      BM.stop_cond();
      check_events();
      @(negedge core_clk);
      mact = 1'b1;
      ev(9, 8'hFF, 8'h8E, 1);
      ev(s == 1 ? 9 : 8, 8'hFF, s == 1 ? 8'h44 : 8'h40, 0);
      ev(0, 8'h3F, 8'h01, 2);
      BM.start_cond();
      BM.send_byte({2'b10, r[12:8], 1'b0}, 1'b1);
      fork
        BM.send_byte(r[7:0], 1'b1);
        begin
          #40;
          @(negedge core_clk);
          aloss = 1'b1;
          mact = 1'b0;
          @(negedge core_clk);
          aloss = 1'b0;
        end
      join
      BM.stop_cond();
      check_events();
      clear_loss();
      // Loss while sending an extension code, then software drops out
      mact = 1'b1;
      ev(8, 8'hF7, 8'h62, 2);
      ev(0, 8'h3F, 8'h01, 2);
      BM.start_cond();
      fork
        BM.send_byte(8'h00, 1'b0);
        begin
          #20;
          @(negedge core_clk);
          aloss = 1'b1;
          mact = 1'b0;
          @(negedge core_clk);
          aloss = 1'b0;
          @(posedge irq);
          @(negedge core_clk);
          lrel = 1'b1;
          @(negedge core_clk);
          lrel = 1'b0;
        end
      join
      check1(ack_low, 1'b0);
      BM.send_byte(r[15:8], 1'b0);
      BM.stop_cond();
      check_events();
      clear_loss();
    end
    check1(scl_o | sda_o, 1'b0);
    finish_test();
  end
endmodule // i2c_event_timing_and_wait_control_bench
